/* File: pkg/lphy_pkg.sv */
// Package for the LIN physical layer control register bank.
// Assumes a 32-bit AXI4-Lite host and a transceiver core on sys_clk.
package lphy_pkg;
  // Word offsets are indices; byte address is four times the index
  localparam logic [2:0] IDX_PIN_DATA = 3'h0;
  localparam logic [2:0] IDX_CTRL = 3'h1;
  localparam logic [2:0] IDX_TEST_A = 3'h2;
  localparam logic [2:0] IDX_SLEW = 3'h3;
  localparam logic [2:0] IDX_TEST_B = 3'h4;
  localparam logic [2:0] IDX_OC_STATUS = 3'h5;
  localparam logic [2:0] IDX_IRQ_EN = 3'h6;
  localparam logic [2:0] IDX_IRQ_FLAGS = 3'h7;
  localparam int ADDR_W = 5;
  // Field positions
  localparam int BIT_RX_LEVEL = 0;
  localparam int BIT_TX_DRIVE = 1;
  localparam int BIT_PULLUP = 0;
  localparam int BIT_WAKEUP = 1;
  localparam int BIT_LISTEN = 2;
  localparam int BIT_ENABLE = 3;
  localparam int BIT_SLEW_LOCK = 7;
  localparam int BIT_OC = 0;
  localparam int BIT_OC_IE = 7;
  localparam int BIT_OC_IF = 0;
  // Reset values
  localparam logic [7:0] RST_PIN_DATA = 8'h02;
  localparam logic [7:0] RST_CTRL = 8'h01;
  localparam logic [1:0] RST_SLEW = 2'h0;
  localparam logic [7:0] RST_TEST = 8'h00;
  // Slew sync countdown start; latency is one cycle more
  localparam logic [1:0] SLEW_SYNC_CYC = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LPHY_SLEW_NORMAL = 2'h0,
    LPHY_SLEW_SLOW = 2'h1,
    LPHY_SLEW_FAST = 2'h2,
    LPHY_SLEW_RSVD = 2'h3
  } lphy_slew_t;

  // Outputs to the transceiver core
  typedef struct packed {
    logic tx_in;
    logic enable;
    logic tx_enable;
    logic wakeup_en;
    logic strong_pullup;
    lphy_slew_t slew;
  } lphy_phy_ctrl_t;

  // Inputs from the transceiver core
  typedef struct packed {
    logic rx_out;
    logic overcurrent;
  } lphy_phy_stat_t;
endpackage : lphy_pkg

/* File: design/lphy_regs.sv */
// LIN physical layer control registers behind an AXI4-Lite slave.
// Assumes phy status inputs are synchronous to sys_clk.
// Function
// - Eight registers at consecutive offsets, offset zero is pin data.
// - Pin data bit one drives the transceiver transmit input.
// - Pin data bit zero is read-only, shows receive output.
// - Enable bit zero means shutdown with only weak pull-up active.
// - Listen-only bit set means receive-only mode, clear means not.
// - Receive-only mode disables transmitter, receiver stays active.
// - Wake-up enable permits standby bus wake-up detection.
// - Pull-up select zero weak, one strong only when enabled.
// - Slew lock sets after slew write, clears after synchronization.
// - Slew writes ignored while lock flag is set.
// - Slew codes: 00 normal, 01 slow, 10 fast, 11 reserved.
// - Test registers readable always, writable only in test mode.
// - Pin data and control registers accessible at any time.
// - Status bit zero shows present transmitter over-current.
// - Over-current change flag sets on change, write-one clears.
module lphy_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Chip test mode strap
  input wire logic test_mode,
  // AXI4-Lite write
  input wire logic [lphy_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [lphy_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Transceiver
  output lphy_pkg::lphy_phy_ctrl_t phy_ctrl,
  input wire lphy_pkg::lphy_phy_stat_t phy_stat,
  // Interrupt
  output logic irq
);
  import lphy_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Write channel capture
  logic aw_q, w_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic wr_go;
  logic [2:0] wr_idx;
  logic wr_byte;

  assign awready = !aw_q && !bvalid;
  assign wready = !w_q && !bvalid;
  assign wr_go = aw_q && w_q && !bvalid;
  assign wr_idx = awaddr_q[4:2];
  assign wr_byte = wr_go && wstrb0_q;

  function automatic logic hit(input logic [2:0] idx, input logic [2:0] r);
    hit = (idx == r);
  endfunction : hit

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awaddr_q <= awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wdata_q <= wdata;
        wstrb0_q <= wstrb[0];
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= (awaddr_q[1:0] != 2'h0) ? AXI_SLVERR : AXI_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic tx_drive_bit_q;
  logic [3:0] ctrl_q;
  logic [7:0] test_a_q, test_b_q;
  lphy_slew_t slew_q;
  logic slew_lock_q;
  logic [1:0] sync_cnt_q;
  logic oc_ie_q, oc_if_q, oc_prev_q;
  logic oc_changed;
  logic wr_ok;

  assign wr_ok = wr_byte && awaddr_q[1:0] == 2'h0;
  assign oc_changed = phy_stat.overcurrent != oc_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_drive_bit_q <= RST_PIN_DATA[BIT_TX_DRIVE];
    end else if (wr_ok && hit(wr_idx, IDX_PIN_DATA)) begin
      tx_drive_bit_q <= wdata_q[BIT_TX_DRIVE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_q <= RST_CTRL[3:0];
    end else begin
      if (wr_ok && hit(wr_idx, IDX_CTRL)) begin
        ctrl_q <= wdata_q[3:0];
      end
      if (phy_stat.overcurrent) begin
        ctrl_q[BIT_LISTEN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      test_a_q <= RST_TEST;
      test_b_q <= RST_TEST;
    end else if (wr_ok && test_mode) begin
      if (hit(wr_idx, IDX_TEST_A)) begin
        test_a_q <= wdata_q[7:0];
      end
      if (hit(wr_idx, IDX_TEST_B)) begin
        test_b_q <= wdata_q[7:0];
      end
    end
  end

  // Slew field with write lock held during synchronization
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slew_q <= LPHY_SLEW_NORMAL;
      slew_lock_q <= 1'b0;
      sync_cnt_q <= '0;
    end else if (wr_ok && hit(wr_idx, IDX_SLEW) && !slew_lock_q) begin
      slew_q <= lphy_slew_t'(wdata_q[1:0]);
      slew_lock_q <= 1'b1;
      sync_cnt_q <= SLEW_SYNC_CYC;
    end else if (slew_lock_q) begin
      if (sync_cnt_q == 2'h0) begin
        slew_lock_q <= 1'b0;
      end else begin
        sync_cnt_q <= sync_cnt_q - 2'h1;
      end
    end
  end

  // Transceiver slew output updates when synchronization completes
  lphy_slew_t slew_phy_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slew_phy_q <= LPHY_SLEW_NORMAL;
    end else if (slew_lock_q && sync_cnt_q == 2'h0) begin
      slew_phy_q <= slew_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      oc_ie_q <= 1'b0;
    end else if (wr_ok && hit(wr_idx, IDX_IRQ_EN)) begin
      oc_ie_q <= wdata_q[BIT_OC_IE];
    end
  end

  // Change flag: set wins over write-one clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      oc_prev_q <= 1'b0;
      oc_if_q <= 1'b0;
    end else begin
      oc_prev_q <= phy_stat.overcurrent;
      if (oc_changed) begin
        oc_if_q <= 1'b1;
      end else if (wr_ok && hit(wr_idx, IDX_IRQ_FLAGS)
                   && wdata_q[BIT_OC_IF]) begin
        oc_if_q <= 1'b0;
      end
    end
  end

  assign irq = oc_ie_q && oc_if_q;

  //////////////////////////////////////////////////////////////////////////
  // Transceiver controls
  always_comb begin
    phy_ctrl.tx_in = tx_drive_bit_q;
    phy_ctrl.enable = ctrl_q[BIT_ENABLE];
    phy_ctrl.tx_enable = ctrl_q[BIT_ENABLE] && !ctrl_q[BIT_LISTEN]
                         && !phy_stat.overcurrent;
    phy_ctrl.wakeup_en = ctrl_q[BIT_ENABLE] && ctrl_q[BIT_WAKEUP];
    phy_ctrl.strong_pullup = ctrl_q[BIT_ENABLE]
                             && ctrl_q[BIT_PULLUP];
    phy_ctrl.slew = slew_phy_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [7:0] rd_byte;
  logic [2:0] rd_idx;
  assign rd_idx = araddr[4:2];
  assign arready = !rvalid;

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      IDX_PIN_DATA: begin
        rd_byte[BIT_TX_DRIVE] = tx_drive_bit_q;
        rd_byte[BIT_RX_LEVEL] = phy_stat.rx_out;
      end
      IDX_CTRL: rd_byte[3:0] = ctrl_q;
      IDX_TEST_A: rd_byte = test_a_q;
      IDX_SLEW: begin
        rd_byte[BIT_SLEW_LOCK] = slew_lock_q;
        rd_byte[1:0] = slew_q;
      end
      IDX_TEST_B: rd_byte = test_b_q;
      IDX_OC_STATUS: rd_byte[BIT_OC] = phy_stat.overcurrent;
      IDX_IRQ_EN: rd_byte[BIT_OC_IE] = oc_ie_q;
      IDX_IRQ_FLAGS: rd_byte[BIT_OC_IF] = oc_if_q;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= AXI_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= (araddr[1:0] != 2'h0) ? AXI_SLVERR : AXI_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_oc_listen;
    @(posedge sys_clk) disable iff (!nrst)
      phy_stat.overcurrent |=> ctrl_q[BIT_LISTEN];
  endproperty
  a_oc_listen: assert property (p_oc_listen)
    else $error("listen-only not forced by over-current");

  property p_tx_off;
    @(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[BIT_LISTEN] || !ctrl_q[BIT_ENABLE]) |-> !phy_ctrl.tx_enable;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("transmitter enabled in listen-only or shutdown");

  property p_pullup;
    @(posedge sys_clk) disable iff (!nrst)
      phy_ctrl.strong_pullup |-> ctrl_q[BIT_ENABLE] && ctrl_q[BIT_PULLUP];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("strong pull-up without enable");

  property p_lock_set;
    @(posedge sys_clk) disable iff (!nrst)
      (wr_ok && hit(wr_idx, IDX_SLEW) && !slew_lock_q) |=> slew_lock_q;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("slew lock not set after write");

  property p_lock_clear;
    @(posedge sys_clk) disable iff (!nrst)
      $rose(slew_lock_q) |-> ##[1:4] !slew_lock_q;
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("slew lock stuck");

  property p_slew_hold;
    @(posedge sys_clk) disable iff (!nrst)
      slew_lock_q |=> $stable(slew_q);
  endproperty
  a_slew_hold: assert property (p_slew_hold)
    else $error("slew changed while locked");

  property p_test_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !test_mode |=> $stable(test_a_q) && $stable(test_b_q);
  endproperty
  a_test_hold: assert property (p_test_hold)
    else $error("test register written outside test mode");

  property p_flag_set;
    @(posedge sys_clk) disable iff (!nrst)
      oc_changed |=> oc_if_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("change flag not set");

  property p_irq;
    @(posedge sys_clk) disable iff (!nrst)
      oc_changed |=> irq == oc_ie_q;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output mismatch");

  property p_txin;
    @(posedge sys_clk) disable iff (!nrst)
      (wr_ok && hit(wr_idx, IDX_PIN_DATA)) |=>
        phy_ctrl.tx_in == $past(wdata_q[BIT_TX_DRIVE]);
  endproperty
  a_txin: assert property (p_txin)
    else $error("tx input does not follow pin data write");

  c_slew_write: cover property (@(posedge sys_clk) $fell(slew_lock_q));
  c_oc_event: cover property (@(posedge sys_clk) $rose(phy_stat.overcurrent));
  c_irq: cover property (@(posedge sys_clk) $rose(irq));
endmodule : lphy_regs

/* File: sim/lphy_phy_model.sv */
// Transceiver core model: echoes the transmit level onto the bus.
// Assumes the bench raises oc_req to inject an over-current fault.
module lphy_phy_model (
  // From the register bank
  input wire lphy_pkg::lphy_phy_ctrl_t ctrl,
  // Fault injection
  input wire logic oc_req,
  // To the register bank
  output lphy_pkg::lphy_phy_stat_t stat
);
  timeunit 1ns;
  timeprecision 1ps;
  import lphy_pkg::*;
  logic rx_level;
  // Bus stays recessive unless an enabled transmitter pulls it low
  assign rx_level = (ctrl.enable && ctrl.tx_enable) ? ctrl.tx_in : 1'b1;
  assign stat = {rx_level, oc_req};
endmodule : lphy_phy_model

/* File: sim/lphy_regs_bench.sv */
// Self-checking bench for the LIN physical layer register bank.
// Assumes lphy_pkg, lphy_regs and lphy_phy_model are compiled first.
module lphy_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lphy_pkg::*;
  logic sys_clk = 0, nrst = 0, test_mode = 0, oc_req = 0;
  logic [4:0] awaddr = '0, araddr = '0;
  // Response readies stay high so back-to-back calls never retoggle them
  logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  lphy_phy_ctrl_t phy_ctrl;
  lphy_phy_stat_t phy_stat;
  int fail_count = 0, cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  lphy_regs u_lphy_regs (.sys_clk, .nrst, .test_mode, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .phy_ctrl, .phy_stat, .irq);
  lphy_phy_model u_lphy_phy_model (.ctrl(phy_ctrl), .oc_req,
    .stat(phy_stat));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // Handshakes are judged at the falling edge, acted on at the next rise
  task automatic wr(input logic [2:0] i, input logic [7:0] d,
                    input logic [3:0] s = 4'hF, input logic [1:0] lo = 0);
    logic ta, tw, tb;
    logic [1:0] r;
    awaddr <= {i, lo};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(negedge sys_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
    chk(32'(r), 32'(lo != 0 ? AXI_SLVERR : AXI_OKAY), "bresp");
  endtask : wr
  task automatic rd(input logic [2:0] i, output logic [31:0] v);
    logic ta, tr;
    logic [1:0] r;
    araddr <= {i, 2'h0};
    arvalid <= 1;
    do begin
      @(negedge sys_clk);
      ta = arvalid & arready;
      tr = rvalid;
      v = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ta) arvalid <= 0;
    end while (!tr);
    chk(32'(r), 32'(AXI_OKAY), "rresp");
  endtask : rd
  task automatic rc(input logic [2:0] i, input logic [7:0] e);
    logic [31:0] v;
    rd(i, v);
    chk(v, {24'h0, e}, "read data");
  endtask : rc
  task automatic pcc(input logic [6:0] e, m);
    chk(32'(phy_ctrl & m), 32'(e & m), "phy ctrl");
  endtask : pcc
  task automatic settle(output logic [31:0] v);
    for (int k = 0; k < 8; k++) begin
      rd(IDX_SLEW, v);
      if (!v[7]) break;
    end
  endtask : settle
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] e [8] = '{8'h03, RST_CTRL, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rc(3'(i), e[i]);
    pcc(7'h40, 7'h77);
  endtask : t_reset
  task automatic t_ctrl;
    wr(IDX_PIN_DATA, 8'h00);
    pcc(7'h00, 7'h40);
    wr(IDX_CTRL, 8'hFF);
    rc(IDX_CTRL, 8'h0F);
    pcc(7'h2C, 7'h7C);
    rc(IDX_PIN_DATA, 8'h01);
    wr(IDX_CTRL, 8'h08);
    pcc(7'h30, 7'h7C);
    rc(IDX_PIN_DATA, 8'h00);
    wr(IDX_PIN_DATA, 8'hFF);
    rc(IDX_PIN_DATA, 8'h03);
    wr(IDX_CTRL, 8'h01);
    pcc(7'h40, 7'h77);
  endtask : t_ctrl
  task automatic t_slew;
    logic [31:0] v;
    logic [1:0] s;
    wr(IDX_SLEW, 8'hFE);
    rc(IDX_SLEW, 8'h82);
    for (int c = 0; c < 4; c++) begin
      s = 2'(c);
      settle(v);
      wr(IDX_SLEW, {6'h0, s});
      wr(IDX_SLEW, {6'h0, ~s});
      settle(v);
      chk(v, {30'h0, s}, "slew");
      pcc({5'h0, s}, 7'h03);
    end
  endtask : t_slew
  task automatic t_test;
    logic [2:0] i;
    for (int k = 0; k < 2; k++) begin
      i = k ? IDX_TEST_B : IDX_TEST_A;
      wr(i, 8'hA5);
      rc(i, 8'h00);
      test_mode <= 1;
      wr(i, 8'h5A);
      rc(i, 8'h5A);
      test_mode <= 0;
    end
  endtask : t_test
  task automatic t_oc;
    wr(IDX_CTRL, 8'h08);
    wr(IDX_IRQ_EN, 8'hFF);
    rc(IDX_IRQ_EN, 8'h80);
    oc_req <= 1;
    repeat (2) @(posedge sys_clk);
    rc(IDX_OC_STATUS, 8'h01);
    rc(IDX_IRQ_FLAGS, 8'h01);
    chk(32'(irq), 1, "irq raised");
    wr(IDX_CTRL, 8'h08);
    rc(IDX_CTRL, 8'h0C);
    pcc(7'h00, 7'h10);
    wr(IDX_IRQ_FLAGS, 8'h00);
    rc(IDX_IRQ_FLAGS, 8'h01);
    wr(IDX_IRQ_FLAGS, 8'h01);
    rc(IDX_IRQ_FLAGS, 8'h00);
    chk(32'(irq), 0, "irq cleared");
    oc_req <= 0;
    repeat (2) @(posedge sys_clk);
    rc(IDX_OC_STATUS, 8'h00);
    rc(IDX_IRQ_FLAGS, 8'h01);
    wr(IDX_IRQ_EN, 8'h00);
    chk(32'(irq), 0, "irq masked");
    wr(IDX_CTRL, 8'h08);
    rc(IDX_CTRL, 8'h08);
    pcc(7'h10, 7'h10);
    wr(IDX_IRQ_EN, 8'h80, 4'h0);
    wr(IDX_IRQ_EN, 8'h80, 4'hF, 2'h1);
    rc(IDX_IRQ_EN, 8'h00);
  endtask : t_oc
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    t_reset();
    t_ctrl();
    t_slew();
    t_test();
    t_oc();
    // Mid-run reset must bring every register back to its reset value
    nrst <= 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    t_reset();
    wrap_up();
  end
  initial begin
    #200us;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : lphy_regs_bench
